/* bench/pfv_flash_model.sv */
`timescale 1ns/1ps
`include "pfv_params.svh"

// Combinational flash stand-in that answers every address below 32 Kbytes with a nonzero word.
// It returns zero by itself only where fetch_addr[16:1] equals 16'h5A3C, so at the
// addresses the bench checks only the design's gate can make the region above the
// implemented flash read as zero.
module pfv_flash_model
(
  input  wire logic [`PFV_PC_W-1:0]   fetch_addr,
  output logic      [`PFV_WORD_W-1:0] flash_rdata
);
  // The word pattern follows the word address, so a stale word is caught.
  assign flash_rdata = fetch_addr[16:1] ^ 16'h5A3C;
endmodule

/* bench/test_program_fetch_vectoring.sv */
`timescale 1ns/1ps
`include "pfv_params.svh"

// Directed bench for the program counter, fetch gate and vectoring logic.
module test_program_fetch_vectoring import pfv_pkg::*;;
  localparam int          FLASH_KB = 32;          // Smallest flash build option.
  localparam logic [20:0] LIMIT    = 21'h008000;  // First address above 32 Kbytes.

  logic                     clk_sys;              // Core clock, 4 ns period.
  logic                     sys_rst;              // Synchronous reset, active high.
  pfv_op_t                  pc_op;                // Counter action.
  logic [`PFV_PC_W-1:0]     jump_addr;            // Jump or call target.
  logic                     sleep_req;            // Sleep request level.
  pfv_irq_t                 irq_in;               // Interrupt requests and enables.
  logic [`PFV_WORD_W-1:0]   flash_rdata;          // Word from the flash model.
  logic                     data_req;             // Data bus request.
  logic [11:0]              data_addr;            // Data bus address.
  logic [`PFV_PC_W-1:0]     fetch_addr;           // Program counter.
  logic [`PFV_WORD_W-1:0]   instr_word;           // Gated instruction word.
  logic                     data_req_out;         // Forwarded data request.
  logic [11:0]              data_addr_out;        // Forwarded data address.
  logic [`PFV_PC_W-1:0]     top_of_stack;         // Stack entry at the pointer.
  logic [7:0]               top_of_stack_upper;   // Upper byte of that entry.
  logic [7:0]               top_of_stack_high;    // High byte of that entry.
  logic [7:0]               top_of_stack_low;     // Low byte of that entry.
  logic [7:0]               counter_low_byte;     // Low byte of the counter.
  logic [`PFV_SP_W-1:0]     return_stack_pointer; // Stack pointer.
  logic                     asleep;               // Sleep state.
  pfv_wake_t                wake_flags;           // Sticky wake causes.
  logic                     stack_full;           // Sticky full flag.
  logic                     stack_underflow;      // Sticky underflow flag.
  int                       err_total;            // Mismatches seen.
  int                       checks;               // Comparisons made.

  // The clock toggles every half period.
  always #2 clk_sys = ~clk_sys;

  pfv_program_fetch_vectoring #(.FLASH_KB(FLASH_KB)) i_dut
  (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .pc_op(pc_op), .jump_addr(jump_addr),
    .sleep_req(sleep_req), .irq_in(irq_in), .flash_rdata(flash_rdata),
    .data_req(data_req), .data_addr(data_addr), .fetch_addr(fetch_addr),
    .instr_word(instr_word), .data_req_out(data_req_out), .data_addr_out(data_addr_out),
    .top_of_stack(top_of_stack), .top_of_stack_upper(top_of_stack_upper),
    .top_of_stack_high(top_of_stack_high), .top_of_stack_low(top_of_stack_low),
    .counter_low_byte(counter_low_byte), .return_stack_pointer(return_stack_pointer),
    .asleep(asleep), .wake_flags(wake_flags), .stack_full(stack_full),
    .stack_underflow(stack_underflow)
  );

  pfv_flash_model i_flash (.fetch_addr(fetch_addr), .flash_rdata(flash_rdata));

  // Expected flash word, kept apart from the model's own code.
  function automatic logic [15:0] word_of(input logic [20:0] a);
    return a[16:1] ^ 16'h5A3C;
  endfunction

  // Compares one value and counts the result.
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Inputs change at falling edges, so one tick lets exactly one edge act.
  task automatic tick();
    @(negedge clk_sys);
  endtask

  // One-edge reset pulse in mid-run.
  task automatic do_reset();
    sys_rst = 1'b1;
    tick();
    sys_rst = 1'b0;
  endtask

  // Presents one counter action for a single edge.
  task automatic op(input pfv_op_t o, input logic [20:0] a);
    pc_op     = o;
    jump_addr = a;
    tick();
    pc_op     = PFV_OP_HOLD;
  endtask

  // Reset values, both at start and after a reset in mid-run.
  task automatic t_reset();
    chk(fetch_addr, 21'h000000);
    chk(21'(return_stack_pointer), 21'h000000);
    chk(21'(wake_flags), 21'h000000);
    op(PFV_OP_NEXT, 21'h000000);
    do_reset();
    chk(fetch_addr, 21'h000000);
    $display("done: reset");
  endtask

  // Sequential stepping by two with the matching instruction word.
  task automatic t_step();
    op(PFV_OP_NEXT, 21'h000000);
    op(PFV_OP_NEXT, 21'h000000);
    chk(fetch_addr, 21'h000004);
    chk(21'(counter_low_byte), 21'h000004);
    chk(21'(instr_word), 21'(word_of(21'h000002)));
    $display("done: step");
  endtask

  // Odd targets are aligned, and fetches at and above the flash end read zero.
  task automatic t_bound();
    op(PFV_OP_JUMP, LIMIT - 21'h000001);
    chk(fetch_addr, LIMIT - 21'h000002);
    op(PFV_OP_NEXT, 21'h000000);
    chk(fetch_addr, LIMIT);
    chk(21'(instr_word), 21'(word_of(LIMIT - 21'h000002)));
    tick();
    chk(21'(instr_word), 21'h000000);
    op(PFV_OP_JUMP, 21'h1FFFFF);
    chk(fetch_addr, 21'h1FFFFE);
    tick();
    chk(21'(instr_word), 21'h000000);
    $display("done: boundary");
  endtask

  // Call push, return, underflow and a full stack.
  task automatic t_call();
    do_reset();
    op(PFV_OP_JUMP, 21'h010100);
    op(PFV_OP_CALL, 21'h000400);
    chk(fetch_addr, 21'h000400);
    chk(21'(return_stack_pointer), 21'h000001);
    chk(top_of_stack, 21'h010102);
    chk({top_of_stack_upper[4:0], top_of_stack_high, top_of_stack_low}, 21'h010102);
    op(PFV_OP_RETURN, 21'h000000);
    chk(fetch_addr, 21'h010102);
    op(PFV_OP_RETURN, 21'h000000);
    chk(fetch_addr, 21'h000000);
    chk(21'(stack_underflow), 21'h000001);
    for (int i = 0; i < 31; i++)
      op(PFV_OP_CALL, 21'h000200);
    chk(21'(return_stack_pointer), 21'h00001F);
    chk(21'(stack_full), 21'h000001);
    // One push too many is refused: the pointer and the top entry stay put.
    op(PFV_OP_CALL, 21'h000300);
    chk(21'(return_stack_pointer), 21'h00001F);
    chk(top_of_stack, 21'h000202);
    $display("done: call");
  endtask

  // Interrupts taken while running: both pending, then low alone.
  task automatic t_irq();
    do_reset();
    op(PFV_OP_NEXT, 21'h000000);
    op(PFV_OP_NEXT, 21'h000000);
    irq_in = pfv_irq_t'(4'b1111);
    tick();
    irq_in = pfv_irq_t'(4'b0000);
    chk(fetch_addr, 21'h000008);
    chk(top_of_stack, 21'h000004);
    chk(21'(return_stack_pointer), 21'h000001);
    irq_in = pfv_irq_t'(4'b0101);
    tick();
    irq_in = pfv_irq_t'(4'b0000);
    chk(fetch_addr, 21'h000018);
    chk(top_of_stack, 21'h000008);
    $display("done: interrupt");
  endtask

  // Sleep and wake: low with its enable, high with no enable, then low again.
  task automatic t_wake();
    do_reset();
    op(PFV_OP_JUMP, 21'h000040);
    sleep_req = 1'b1;
    tick();
    sleep_req = 1'b0;
    chk(21'(asleep), 21'h000001);
    irq_in = pfv_irq_t'(4'b0101);
    tick();
    irq_in = pfv_irq_t'(4'b0000);
    chk(21'(wake_flags), 21'h000001);
    tick();
    chk(fetch_addr, 21'h000018);
    chk(top_of_stack, 21'h000040);
    chk(21'(return_stack_pointer), 21'h000001);
    chk(21'(asleep), 21'h000000);
    // A request with no enable set wakes the core but neither pushes nor vectors.
    sleep_req = 1'b1;
    tick();
    sleep_req = 1'b0;
    irq_in = pfv_irq_t'(4'b1000);
    tick();
    irq_in = pfv_irq_t'(4'b0000);
    chk(21'(wake_flags), 21'h000003);
    chk(21'(asleep), 21'h000000);
    chk(21'(return_stack_pointer), 21'h000001);
    chk(fetch_addr, 21'h000018);
    // The older high flag stays set; the vector must follow the new low cause.
    op(PFV_OP_JUMP, 21'h000060);
    sleep_req = 1'b1;
    tick();
    sleep_req = 1'b0;
    irq_in = pfv_irq_t'(4'b0101);
    tick();
    irq_in = pfv_irq_t'(4'b0000);
    tick();
    chk(fetch_addr, 21'h000018);
    chk(top_of_stack, 21'h000060);
    chk(21'(return_stack_pointer), 21'h000002);
    $display("done: wake");
  endtask

  // A data access travels in the same cycle as a fetch step.
  task automatic t_data();
    data_req  = 1'b1;
    data_addr = 12'hA5C;
    op(PFV_OP_NEXT, 21'h000000);
    data_req  = 1'b0;
    chk(21'(data_req_out), 21'h000001);
    chk(21'(data_addr_out), 21'h000A5C);
    chk(fetch_addr, 21'h00001A);
    $display("done: data");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence after a ten-cycle reset.
  initial
  begin
    clk_sys = 1'b0; sys_rst = 1'b1; pc_op = PFV_OP_HOLD; jump_addr = 21'h000000;
    sleep_req = 1'b0; irq_in = pfv_irq_t'(4'b0000); data_req = 1'b0; data_addr = 12'h000;
    err_total = 0; checks = 0;
    repeat (10) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_reset(); t_step(); t_bound(); t_call(); t_irq(); t_wake(); t_data();
    stop_test();
  end

  // The tests need about 75 cycles; a hang is cut short well past that.
  initial
  begin
    #4000;
    err_total++;
    $display("watchdog expired");
    stop_test();
  end
endmodule

/* core/pfv_fetch_gate.sv */
`timescale 1ns/1ps
`include "pfv_params.svh"

// Registered program-memory read port that returns zero above the flash.
module pfv_fetch_gate
  import pfv_pkg::*;
#(
  parameter int FLASH_KB = `PFV_FLASH_128K
)
(
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic [`PFV_PC_W-1:0]     fetch_addr,
  input  wire logic [`PFV_WORD_W-1:0]   flash_rdata,
  output logic      [`PFV_WORD_W-1:0]   instr_word
);

  // Byte limit of the implemented flash.
  localparam logic [`PFV_PC_W-1:0] FLASH_LIMIT = `PFV_PC_W'(FLASH_KB * `PFV_KBYTE);

  // Next fetched word.
  logic [`PFV_WORD_W-1:0] word_nxt;

  // Any address at or above the limit reads as a no-operation.
  always_comb
  begin
    if (fetch_addr >= FLASH_LIMIT)
    begin
      word_nxt = '0; // RULE_02
    end
    else
    begin
      word_nxt = flash_rdata;
    end
  end

  // Register the word so the core sees it from a flip-flop.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      instr_word <= '0;
    end
    else
    begin
      instr_word <= word_nxt;
    end
  end

endmodule

/* core/pfv_params.svh */
`ifndef PFV_PARAMS_SVH
`define PFV_PARAMS_SVH

// Program counter, word and stack-pointer widths, and the stack depth.
`define PFV_PC_W          21
`define PFV_WORD_W        16
`define PFV_SP_W          5
`define PFV_STACK_DEPTH   31

// Hard vectors.
`define PFV_RESET_VEC     21'h000000
`define PFV_HIGH_VEC      21'h000008
`define PFV_LOW_VEC       21'h000018

// Flash size choices in Kbytes and the bytes per Kbyte.
`define PFV_FLASH_32K     32
`define PFV_FLASH_64K     64
`define PFV_FLASH_128K    128
`define PFV_KBYTE         1024

// Sequential step in bytes per instruction word.
`define PFV_PC_STEP       21'h000002

`endif

/* core/pfv_pkg.sv */
package pfv_pkg;

  // Program-counter action requested by the core for the next cycle.
  typedef enum logic [2:0]
  {
    PFV_OP_HOLD,
    PFV_OP_NEXT,
    PFV_OP_JUMP,
    PFV_OP_CALL,
    PFV_OP_RETURN
  } pfv_op_t;

  // Interrupt request bundle from the interrupt sources.
  typedef struct packed
  {
    logic high_req;
    logic low_req;
    logic high_priority_global_enable;
    logic low_priority_global_enable;
  } pfv_irq_t;

  // Wake-cause flags offered to the interrupt control and flag registers.
  typedef struct packed
  {
    logic high_flag;
    logic low_flag;
  } pfv_wake_t;

  // Phases of the vectoring sequence.
  typedef enum logic [1:0]
  {
    PFV_RUN,
    PFV_SLEEP,
    PFV_VECTOR
  } pfv_state_t;

endpackage

/* core/pfv_program_fetch_vectoring.sv */
`timescale 1ns/1ps
`include "pfv_params.svh"

// Operation
// RULE_01: Program counter is 21 bits wide.
// RULE_02: Fetches above flash return zero word.
// RULE_03: Flash size parameter: 32, 64, 128 Kbytes.
// RULE_04: Every reset loads counter with 0000h.
// RULE_05: High-priority interrupt vectors to 0008h.
// RULE_06: Low-priority interrupt vectors to 0018h.
// RULE_07: Interrupt wake pushes counter, advances pointer.
// RULE_08: Interrupt wake loads the waking vector.
// RULE_09: Wake leaves a cause flag set.
// RULE_10: Fetch and data buses are separate.
// RULE_11: Counter bit zero fixed; steps by two.
// RULE_12: Push increments pointer, then writes entry.
// RULE_13: High priority wins over low.
module pfv_program_fetch_vectoring
  import pfv_pkg::*;
#(
  parameter int FLASH_KB = `PFV_FLASH_128K
)
(
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire pfv_op_t                  pc_op,
  input  wire logic [`PFV_PC_W-1:0]     jump_addr,
  input  wire logic                     sleep_req,
  input  wire pfv_irq_t                 irq_in,
  input  wire logic [`PFV_WORD_W-1:0]   flash_rdata,
  input  wire logic                     data_req,
  input  wire logic [11:0]              data_addr,
  output logic      [`PFV_PC_W-1:0]     fetch_addr,
  output logic      [`PFV_WORD_W-1:0]   instr_word,
  output logic                          data_req_out,
  output logic      [11:0]              data_addr_out,
  output logic      [`PFV_PC_W-1:0]     top_of_stack,
  output logic      [7:0]               top_of_stack_upper,
  output logic      [7:0]               top_of_stack_high,
  output logic      [7:0]               top_of_stack_low,
  output logic      [7:0]               counter_low_byte,
  output logic      [`PFV_SP_W-1:0]     return_stack_pointer,
  output logic                          asleep,
  output pfv_wake_t                     wake_flags,
  output logic                          stack_full,
  output logic                          stack_underflow
);

  // Only the three documented flash sizes are legal builds.
  initial
  begin
    assert (FLASH_KB == `PFV_FLASH_32K || FLASH_KB == `PFV_FLASH_64K ||
            FLASH_KB == `PFV_FLASH_128K)
      else $error("flash size must be 32, 64 or 128 Kbytes"); // RULE_03
  end

  // Program counter and its next value; bit zero never leaves zero.
  logic [`PFV_PC_W-1:0]   pc_r;   // RULE_01
  logic [`PFV_PC_W-1:0]   pc_nxt;
  // Stack pointer; entry zero holds no storage and is the reset value.
  logic [`PFV_SP_W-1:0]   sp_r;
  logic [`PFV_SP_W-1:0]   sp_nxt;
  // Return address storage, entries 1 to 31.
  logic [`PFV_PC_W-1:0]   stack_mem [1:`PFV_STACK_DEPTH];
  logic                   push_en;
  logic [`PFV_PC_W-1:0]   push_val;
  // Sequencer state.
  pfv_state_t             state_r;
  pfv_state_t             state_nxt;
  // Sticky status and wake flags.
  logic                   full_r;
  logic                   full_nxt;
  logic                   unf_r;
  logic                   unf_nxt;
  pfv_wake_t              wake_r;
  pfv_wake_t              wake_nxt;
  // Cause of the wake being served; the sticky flags may still hold an older
  // cause, so the vector follows the request that actually woke the core.
  logic                   wake_hi_r;
  logic                   wake_hi_nxt;
  // Sleep indication, registered so the port comes from a flip-flop.
  logic                   asleep_r;
  logic                   asleep_nxt;
  // Data-bus pass-through registers, kept apart from the fetch path.
  logic                   dreq_r;
  logic [11:0]            daddr_r;

  // Clears bit zero so the counter stays word aligned.
  function automatic logic [`PFV_PC_W-1:0] align(input logic [`PFV_PC_W-1:0] a);
    align = {a[`PFV_PC_W-1:1], 1'b0}; // RULE_11
  endfunction

  // Picks the vector for a request; high priority first.
  function automatic logic [`PFV_PC_W-1:0] pick_vec(input pfv_irq_t q);
    if (q.high_req)
    begin
      pick_vec = `PFV_HIGH_VEC; // RULE_05 RULE_13
    end
    else
    begin
      pick_vec = `PFV_LOW_VEC; // RULE_06
    end
  endfunction

  // An interrupt may be taken when a request meets an open global enable.
  logic irq_take;
  assign irq_take = (irq_in.high_req || irq_in.low_req) &&
                    (irq_in.high_priority_global_enable ||
                     irq_in.low_priority_global_enable);

  // Next-state logic for counter, stack, sleep and flags.
  always_comb
  begin
    pc_nxt    = pc_r;
    sp_nxt    = sp_r;
    state_nxt = state_r;
    full_nxt  = full_r;
    unf_nxt   = unf_r;
    wake_nxt  = wake_r;
    wake_hi_nxt = wake_hi_r;
    push_en   = 1'b0;
    push_val  = pc_r;
    unique case (state_r)
      PFV_RUN:
      begin
        if (irq_take)
        begin
          // Taking an interrupt pushes the return address and vectors.
          push_en = 1'b1;
          pc_nxt  = pick_vec(irq_in);
        end
        else if (sleep_req)
        begin
          state_nxt = PFV_SLEEP;
        end
        else
        begin
          unique case (pc_op)
            PFV_OP_NEXT:   pc_nxt = align(pc_r + `PFV_PC_STEP); // RULE_11
            PFV_OP_JUMP:   pc_nxt = align(jump_addr);
            PFV_OP_CALL:
            begin
              push_en  = 1'b1;
              push_val = pc_r + `PFV_PC_STEP;
              pc_nxt   = align(jump_addr);
            end
            PFV_OP_RETURN:
            begin
              if (sp_r == '0)
              begin
                // Underflow returns to the reset vector and stays at zero.
                pc_nxt  = `PFV_RESET_VEC;
                unf_nxt = 1'b1;
              end
              else
              begin
                pc_nxt = align(stack_mem[sp_r]);
                sp_nxt = sp_r - 1'b1;
              end
            end
            default:       pc_nxt = pc_r;
          endcase
        end
      end
      PFV_SLEEP:
      begin
        // Any request wakes the core; the cause is latched in a flag.
        if (irq_in.high_req || irq_in.low_req)
        begin
          wake_nxt.high_flag = wake_r.high_flag | irq_in.high_req; // RULE_09
          wake_nxt.low_flag  = wake_r.low_flag | irq_in.low_req;   // RULE_09
          wake_hi_nxt        = irq_in.high_req; // RULE_08 RULE_13
          state_nxt = irq_take ? PFV_VECTOR : PFV_RUN;
        end
      end
      PFV_VECTOR:
      begin
        // Wake with an enable set: push the counter and vector.
        push_en   = 1'b1;                         // RULE_07
        pc_nxt    = wake_hi_r ? `PFV_HIGH_VEC : `PFV_LOW_VEC; // RULE_08
        state_nxt = PFV_RUN;
      end
      default:
      begin
        state_nxt = PFV_RUN;
      end
    endcase
    // Push: the pointer moves first, then its entry is written.
    if (push_en)
    begin
      if (sp_r == `PFV_SP_W'(`PFV_STACK_DEPTH))
      begin
        // Further pushes neither move the pointer nor overwrite.
        full_nxt = 1'b1;
        push_en  = 1'b0;
      end
      else
      begin
        sp_nxt = sp_r + 1'b1; // RULE_07 RULE_12
        if (sp_nxt == `PFV_SP_W'(`PFV_STACK_DEPTH))
        begin
          full_nxt = 1'b1;
        end
      end
    end
    // The port shows sleep one edge after the decision, like every other state.
    asleep_nxt = (state_nxt == PFV_SLEEP);
  end

  // Register all control state; every reset returns to the reset vector.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pc_r    <= `PFV_RESET_VEC; // RULE_04
      sp_r    <= '0;
      state_r <= PFV_RUN;
      full_r  <= 1'b0;
      unf_r   <= 1'b0;
      wake_r  <= '0;
      wake_hi_r <= 1'b0;
      asleep_r  <= 1'b0;
      dreq_r  <= 1'b0;
      daddr_r <= '0;
    end
    else
    begin
      pc_r    <= pc_nxt;
      sp_r    <= sp_nxt;
      state_r <= state_nxt;
      full_r  <= full_nxt;
      unf_r   <= unf_nxt;
      wake_r  <= wake_nxt;
      wake_hi_r <= wake_hi_nxt;
      asleep_r  <= asleep_nxt;
      dreq_r  <= data_req;  // RULE_10
      daddr_r <= data_addr; // RULE_10
    end
  end

  // Stack storage has no reset; an entry is written only on a push.
  always_ff @(posedge clk_sys)
  begin
    if (push_en)
    begin
      stack_mem[sp_nxt] <= push_val; // RULE_12
    end
  end

  // Output register for the stack top, so that port comes from a flip-flop.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      top_of_stack <= '0;
    end
    else if (push_en)
    begin
      top_of_stack <= push_val;
    end
    else if (sp_nxt == '0)
    begin
      top_of_stack <= '0;
    end
    else
    begin
      top_of_stack <= stack_mem[sp_nxt];
    end
  end

  // Fetch port; the gate zeroes words above the implemented flash.
  pfv_fetch_gate #(
    .FLASH_KB (FLASH_KB)
  ) u_gate (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .fetch_addr  (pc_r),
    .flash_rdata (flash_rdata),
    .instr_word  (instr_word)
  );

  // Plain copies of the registered state onto the ports.
  assign fetch_addr           = pc_r;
  assign counter_low_byte     = pc_r[7:0];
  assign return_stack_pointer = sp_r;
  assign top_of_stack_upper   = {3'h0, top_of_stack[20:16]};
  assign top_of_stack_high    = top_of_stack[15:8];
  assign top_of_stack_low     = top_of_stack[7:0];
  assign asleep               = asleep_r;
  assign wake_flags           = wake_r;
  assign stack_full           = full_r;
  assign stack_underflow      = unf_r;
  assign data_req_out         = dreq_r;
  assign data_addr_out        = daddr_r;

  // Checks on the vectoring behaviour.
  pc_aligned_a: assert property ( // RULE_11
    @(posedge clk_sys) disable iff (sys_rst) pc_r[0] == 1'b0)
    else $error("counter lost word alignment");
  reset_vector_a: assert property ( // RULE_04
    @(posedge clk_sys) sys_rst |=> pc_r == `PFV_RESET_VEC)
    else $error("reset vector wrong");
  high_vector_a: assert property ( // RULE_05
    @(posedge clk_sys) disable iff (sys_rst)
    state_r == PFV_RUN && irq_take && irq_in.high_req |=> pc_r == `PFV_HIGH_VEC)
    else $error("high vector wrong");
  low_vector_a: assert property ( // RULE_06
    @(posedge clk_sys) disable iff (sys_rst)
    state_r == PFV_RUN && irq_take && !irq_in.high_req |=> pc_r == `PFV_LOW_VEC)
    else $error("low vector wrong");
  step_two_a: assert property ( // RULE_11
    @(posedge clk_sys) disable iff (sys_rst)
    state_r == PFV_RUN && !irq_take && !sleep_req && pc_op == PFV_OP_NEXT
    |=> pc_r == $past(pc_r) + `PFV_PC_STEP)
    else $error("step not two");
  wake_push_a: assert property ( // RULE_07
    @(posedge clk_sys) disable iff (sys_rst)
    state_r == PFV_VECTOR && sp_r != 5'h1F |=> sp_r == $past(sp_r) + 5'h01
    && top_of_stack == $past(pc_r))
    else $error("wake push wrong");
  wake_vector_a: assert property ( // RULE_08
    @(posedge clk_sys) disable iff (sys_rst)
    state_r == PFV_SLEEP && irq_take && irq_in.high_req |=> ##1 pc_r == `PFV_HIGH_VEC)
    else $error("high wake vector wrong");
  wake_low_a: assert property ( // RULE_08
    @(posedge clk_sys) disable iff (sys_rst)
    state_r == PFV_SLEEP && irq_take && !irq_in.high_req |=> ##1 pc_r == `PFV_LOW_VEC)
    else $error("low wake vector wrong");
  wake_flag_a: assert property ( // RULE_09
    @(posedge clk_sys) disable iff (sys_rst)
    state_r == PFV_SLEEP && state_nxt != PFV_SLEEP |=> wake_r != '0)
    else $error("wake left no flag");

endmodule
